/* include/bspe_pkg.sv */
// package: constants, enums and microinstruction layout for the bit-serial processing element
package bspe_pkg;

  // storage geometry
  localparam int SMALL_DEPTH = 32;
  localparam int LARGE_DEPTH = 64;
  localparam int SMALL_AW = 5;
  localparam int LARGE_AW = 6;
  localparam int NBR_CNT = 8;
  localparam int NBR_SW = 3;
  localparam int BUS_CNT = 2;

  // timing: array step period as a time, converted to reference clock cycles (rounded up)
  localparam int CLK_PERIOD_PS = 5000;
  localparam int ARRAY_PERIOD_PS = 166000;
  localparam int ARRAY_PERIOD_CYC = (ARRAY_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PERIOD_W = 8;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = PERIOD_W'(ARRAY_PERIOD_CYC);
  localparam logic [PERIOD_W-1:0] PERIOD_MIN = 8'h01;

  // register port
  localparam int REG_AW = 4;
  localparam int REG_DW = 32;
  localparam int STEP_CNT_W = 16;
  localparam logic [REG_AW-1:0] ADDR_PERIOD = 4'h0;
  localparam logic [REG_AW-1:0] ADDR_STATUS = 4'h4;
  localparam logic [REG_AW-1:0] ADDR_STEPS = 4'h8;

  // status register field positions
  localparam int ST_LF_BIT = 0;
  localparam int ST_RSF_BIT = 1;
  localparam int ST_VSB_BIT = 2;
  localparam int ST_CSAVE_BIT = 3;
  localparam int ST_EDGE_BIT = 4;

  // status-bit conditioning: code 0 picks the local flag, code k picks large bank bit k+1
  localparam logic [LARGE_AW-1:0] STAT_BANK_OFS = 6'h01;
  localparam logic [2:0] STAT_SEL_LF = 3'h0;

  typedef enum logic [1:0] {
    BSPE_OP2_SMALL = 2'b00,
    BSPE_OP2_DP1 = 2'b01,
    BSPE_OP2_VSB = 2'b10,
    BSPE_OP2_RSF = 2'b11
  } bspe_op2_t;

  typedef enum logic [1:0] {
    BSPE_CIN_ZERO = 2'b00,
    BSPE_CIN_ONE = 2'b01,
    BSPE_CIN_SAVE = 2'b10,
    BSPE_CIN_NBR = 2'b11
  } bspe_cin_t;

  typedef enum logic [1:0] {
    BSPE_OUT_ALU = 2'b00,
    BSPE_OUT_PASS = 2'b01,
    BSPE_OUT_RSF = 2'b10,
    BSPE_OUT_BYPASS = 2'b11
  } bspe_out_t;

  // one microinstruction, broadcast unchanged to every element
  typedef struct packed {
    logic [7:0] sum_fn;
    logic [7:0] carry_fn;
    logic [LARGE_AW-1:0] large_rd;
    logic [SMALL_AW-1:0] small_rd;
    logic [LARGE_AW-1:0] large_wr;
    logic [SMALL_AW-1:0] small_wr;
    bspe_op2_t op2_sel;
    bspe_cin_t cin_sel;
    bspe_out_t out_sel;
    logic [NBR_SW-1:0] nbr_sel;
    logic wr_small;
    logic wr_large;
    logic wr_rsf;
    logic rsf_from_dp1;
    logic wr_vsb;
    logic shift_en;
    logic shift_up;
    logic wr_lf;
    logic save_carry;
    logic edge_cin;
    logic edge_cin_ext;
    logic ld_edge_cin;
    logic edge_bus_sel;
    logic drive_carry_bus;
    logic carry_bus_sel;
    logic cond_en;
    logic cond_val;
    logic [2:0] stat_sel;
  } bspe_uinst_t;

endpackage

/* hdl/bspe_element.sv */
// bit-serial processing element: banks, one-bit alu, data paths, carry chain, register port
// Overview of operation
// RULE1: all elements run the same microinstruction
// RULE2: 32-bit and 64-bit banks, read together
// RULE3: alu gives any function plus carry out
// RULE4: first operand always from large bank
// RULE5: second operand from four selectable sources
// RULE6: result stored to chosen places or output
// RULE7: neighbour bit to alu, flag, or passthrough
// RULE8: eight-neighbour path plus vertical shift path
// RULE9: vertical shift moves one element per step
// RULE10: vertical shift bit loadable from alu
// RULE11: carry in from 0, 1, save, neighbour
// RULE12: edge elements take carry from microinstruction
// RULE13: carry out passed combinationally left or down
// RULE14: step period programmable for ripple settling
// RULE15: boundary bypass forwards broadcast data fast
// RULE16: edge carries loaded from, written to buses
// RULE17: carry saved each step for next bit
// RULE18: storage updates only when selected, else holds
`timescale 1ns/1ps
`default_nettype none

module bspe_element #(
  parameter bit EDGE_CARRY = 1'b0,
  parameter bit BYPASS_EDGE = 1'b0
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire bspe_pkg::bspe_uinst_t UINST_I,
  input wire logic [bspe_pkg::NBR_CNT-1:0] NBR_I,
  input wire logic VSB_ABOVE_I,
  input wire logic VSB_BELOW_I,
  input wire logic CARRY_NBR_I,
  input wire logic BCAST_I,
  input wire logic [bspe_pkg::BUS_CNT-1:0] EDGE_BUS_I,
  input wire logic [bspe_pkg::REG_AW-1:0] REG_ADDR_I,
  input wire logic [bspe_pkg::REG_DW-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [bspe_pkg::REG_DW-1:0] REG_RDATA_O,
  output logic DP1_O,
  output logic CARRY_O,
  output logic VSB_O,
  output logic STEP_O,
  output logic [bspe_pkg::BUS_CNT-1:0] CARRY_BUS_O,
  output logic [bspe_pkg::BUS_CNT-1:0] CARRY_BUS_EN_O
);

  logic [bspe_pkg::SMALL_DEPTH-1:0] bank_small;
  logic [bspe_pkg::LARGE_DEPTH-1:0] bank_large;
  logic rsf;
  logic vsb;
  logic lf;
  logic csave;
  logic edge_cin_q;
  logic [bspe_pkg::PERIOD_W-1:0] period;
  logic [bspe_pkg::PERIOD_W-1:0] phase;
  logic [bspe_pkg::STEP_CNT_W-1:0] steps;
  logic commit;
  logic large_bit;
  logic small_bit;
  logic dp1_in;
  logic op2;
  logic cin;
  logic [2:0] fn_idx;
  logic alu_sum;
  logic alu_carry;
  logic stat_bit;
  logic enabled;
  logic [bspe_pkg::LARGE_AW-1:0] stat_idx;
  logic [bspe_pkg::REG_DW-1:0] next_rdata;

  // step timing: the microinstruction must stay steady for a whole period so that
  // combinational ripple through neighbours settles before the commit edge
  assign commit = (phase == '0); // RULE14

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      phase <= bspe_pkg::PERIOD_RST - bspe_pkg::PERIOD_MIN;
    end
    else if (commit)
    begin
      phase <= period - bspe_pkg::PERIOD_MIN; // RULE14
    end
    else
    begin
      phase <= phase - bspe_pkg::PERIOD_MIN;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      STEP_O <= 1'b0;
      steps <= '0;
    end
    else
    begin
      STEP_O <= commit;
      if (commit)
      begin
        steps <= steps + 16'h0001;
      end
    end
  end

  // register port: period write, status and step count read
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      period <= bspe_pkg::PERIOD_RST;
    end
    else if (REG_WR_I && REG_ADDR_I == bspe_pkg::ADDR_PERIOD)
    begin
      // zero would wrap the phase counter to a 256-cycle step, so it is clamped to one cycle
      if (REG_WDATA_I[bspe_pkg::PERIOD_W-1:0] == '0)
      begin
        period <= bspe_pkg::PERIOD_MIN; // RULE14
      end
      else
      begin
        period <= REG_WDATA_I[bspe_pkg::PERIOD_W-1:0]; // RULE14
      end
    end
  end

  always_comb
  begin
    next_rdata = '0;
    if (REG_ADDR_I == bspe_pkg::ADDR_PERIOD)
    begin
      next_rdata[bspe_pkg::PERIOD_W-1:0] = period;
    end
    else if (REG_ADDR_I == bspe_pkg::ADDR_STATUS)
    begin
      next_rdata[bspe_pkg::ST_LF_BIT] = lf;
      next_rdata[bspe_pkg::ST_RSF_BIT] = rsf;
      next_rdata[bspe_pkg::ST_VSB_BIT] = vsb;
      next_rdata[bspe_pkg::ST_CSAVE_BIT] = csave;
      next_rdata[bspe_pkg::ST_EDGE_BIT] = edge_cin_q;
    end
    else if (REG_ADDR_I == bspe_pkg::ADDR_STEPS)
    begin
      next_rdata[bspe_pkg::STEP_CNT_W-1:0] = steps;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      REG_RDATA_O <= '0;
    end
    else if (REG_RD_I)
    begin
      REG_RDATA_O <= next_rdata;
    end
    else
    begin
      REG_RDATA_O <= '0;
    end
  end

  // operand fetch, both banks read in the same step
  always_comb
  begin
    large_bit = bank_large[UINST_I.large_rd]; // RULE2 RULE4
    small_bit = bank_small[UINST_I.small_rd]; // RULE2
    dp1_in = NBR_I[UINST_I.nbr_sel]; // RULE8
    case (UINST_I.op2_sel) // RULE5
      bspe_pkg::BSPE_OP2_SMALL: op2 = small_bit;
      bspe_pkg::BSPE_OP2_DP1: op2 = dp1_in; // RULE7
      bspe_pkg::BSPE_OP2_VSB: op2 = vsb;
      default: op2 = rsf;
    endcase
  end

  // carry select; edge elements have no neighbour on that side
  always_comb
  begin
    case (UINST_I.cin_sel) // RULE11
      bspe_pkg::BSPE_CIN_ZERO: cin = 1'b0;
      bspe_pkg::BSPE_CIN_ONE: cin = 1'b1;
      bspe_pkg::BSPE_CIN_SAVE: cin = csave;
      default:
      begin
        if (EDGE_CARRY)
        begin
          cin = UINST_I.edge_cin_ext ? edge_cin_q : UINST_I.edge_cin; // RULE12 RULE16
        end
        else
        begin
          cin = CARRY_NBR_I; // RULE13
        end
      end
    endcase
  end

  // one-bit alu as two truth tables indexed by first operand, second operand, carry
  always_comb
  begin
    fn_idx = {large_bit, op2, cin};
    alu_sum = UINST_I.sum_fn[fn_idx]; // RULE3
    alu_carry = UINST_I.carry_fn[fn_idx]; // RULE3
  end

  // besides the EDGE_CARRY and BYPASS_EDGE parameters, status-bit conditioning is the only way an element departs from its neighbours
  always_comb
  begin
    stat_idx = bspe_pkg::LARGE_AW'(UINST_I.stat_sel) + bspe_pkg::STAT_BANK_OFS;
    if (UINST_I.stat_sel == bspe_pkg::STAT_SEL_LF)
    begin
      stat_bit = lf;
    end
    else
    begin
      stat_bit = bank_large[stat_idx];
    end
    enabled = !UINST_I.cond_en || (stat_bit == UINST_I.cond_val); // RULE1
  end

  // ripple outputs are combinational on purpose: a registered copy would add a
  // full step of latency per element and break single-step chains
  always_comb
  begin
    CARRY_O = alu_carry; // RULE13
    case (UINST_I.out_sel) // RULE6
      bspe_pkg::BSPE_OUT_ALU: DP1_O = alu_sum;
      bspe_pkg::BSPE_OUT_PASS: DP1_O = dp1_in; // RULE7
      bspe_pkg::BSPE_OUT_RSF: DP1_O = rsf;
      default: DP1_O = BYPASS_EDGE ? BCAST_I : dp1_in; // RULE15
    endcase
  end

  // register banks, one flip-flop per entry
  genvar gi;
  generate
    for (gi = 0; gi < bspe_pkg::SMALL_DEPTH; gi++)
    begin : g_small
      always_ff @(posedge REF_CLK_I or negedge RST_N_I)
      begin
        if (!RST_N_I)
        begin
          bank_small[gi] <= 1'b0;
        end
        else if (commit && UINST_I.wr_small &&
                 UINST_I.small_wr == bspe_pkg::SMALL_AW'(gi)) // RULE18
        begin
          bank_small[gi] <= alu_sum; // RULE6
        end
      end
    end
    for (gi = 0; gi < bspe_pkg::LARGE_DEPTH; gi++)
    begin : g_large
      always_ff @(posedge REF_CLK_I or negedge RST_N_I)
      begin
        if (!RST_N_I)
        begin
          bank_large[gi] <= 1'b0;
        end
        else if (commit && UINST_I.wr_large && enabled &&
                 UINST_I.large_wr == bspe_pkg::LARGE_AW'(gi)) // RULE18
        begin
          bank_large[gi] <= alu_sum; // RULE6
        end
      end
    end
  endgenerate

  // route select flag: alu result or the raw neighbour bit
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rsf <= 1'b0;
    end
    else if (commit && UINST_I.wr_rsf && enabled) // RULE18
    begin
      rsf <= UINST_I.rsf_from_dp1 ? dp1_in : alu_sum; // RULE6 RULE7
    end
  end

  // vertical shift bit; a shift takes priority over an alu load
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      vsb <= 1'b0;
    end
    else if (commit && UINST_I.shift_en)
    begin
      vsb <= UINST_I.shift_up ? VSB_BELOW_I : VSB_ABOVE_I; // RULE8 RULE9
    end
    else if (commit && UINST_I.wr_vsb)
    begin
      vsb <= alu_sum; // RULE10
    end
  end

  assign VSB_O = vsb; // RULE9

  // local status flag
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      lf <= 1'b0;
    end
    else if (commit && UINST_I.wr_lf) // RULE18
    begin
      lf <= alu_sum; // RULE6
    end
  end

  // carry save for bit-serial arithmetic
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      csave <= 1'b0;
    end
    else if (commit && UINST_I.save_carry) // RULE18
    begin
      csave <= alu_carry; // RULE17
    end
  end

  // edge carry input latch, loaded from either external bus
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      edge_cin_q <= 1'b0;
    end
    else if (commit && UINST_I.ld_edge_cin)
    begin
      edge_cin_q <= EDGE_BUS_I[UINST_I.edge_bus_sel]; // RULE16
    end
  end

  // carry out captured onto the chosen bus at the step edge
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      CARRY_BUS_O <= '0;
      CARRY_BUS_EN_O <= '0;
    end
    else if (commit)
    begin
      CARRY_BUS_EN_O <= '0;
      if (UINST_I.drive_carry_bus)
      begin
        CARRY_BUS_O[UINST_I.carry_bus_sel] <= alu_carry; // RULE16
        CARRY_BUS_EN_O[UINST_I.carry_bus_sel] <= 1'b1; // RULE16
      end
    end
  end

endmodule

`default_nettype wire

/* bench/bspe_nbr_model.sv */
// partner: neighbour elements around one processing element
`timescale 1ns/1ps
`default_nettype none
module bspe_nbr_model (
  input wire logic clk_i,
  input wire logic [10:0] val_i,
  output logic [7:0] nbr_o,
  output logic above_o,
  output logic below_o,
  output logic carry_o
);
  logic [10:0] q;
  // neighbours run the same step, so their bits move only on our clock edge
  always_ff @(posedge clk_i)
    q <= val_i;
  assign {carry_o, below_o, above_o, nbr_o} = q;
endmodule
`default_nettype wire

/* bench/bspe_element_checker.sv */
// checker: port assertions for the processing element
`timescale 1ns/1ps
`default_nettype none
module bspe_element_checker (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire bspe_pkg::bspe_uinst_t UINST_I,
  input wire logic [bspe_pkg::NBR_CNT-1:0] NBR_I,
  input wire logic VSB_ABOVE_I,
  input wire logic VSB_BELOW_I,
  input wire logic DP1_O,
  input wire logic CARRY_O,
  input wire logic VSB_O,
  input wire logic STEP_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  wire logic alu;
  wire logic sh;
  assign alu = UINST_I.out_sel == bspe_pkg::BSPE_OUT_ALU;
  assign sh = UINST_I.shift_en;
  pass_thru_a: assert property (UINST_I.out_sel == bspe_pkg::BSPE_OUT_PASS
    |-> DP1_O == NBR_I[UINST_I.nbr_sel]) else $error("pass bit wrong");
  alu_one_a: assert property (alu && UINST_I.sum_fn == 8'hff |-> DP1_O)
    else $error("alu one wrong");
  op2_nbr_a: assert property (alu && UINST_I.op2_sel == bspe_pkg::BSPE_OP2_DP1
    && UINST_I.sum_fn == 8'hcc |-> DP1_O == NBR_I[UINST_I.nbr_sel]) else $error("op2 wrong");
  cin_one_a: assert property (alu && UINST_I.cin_sel == bspe_pkg::BSPE_CIN_ONE
    && UINST_I.sum_fn == 8'haa |-> DP1_O) else $error("cin one wrong");
  carry_zero_a: assert property (UINST_I.carry_fn == 8'h00 |-> !CARRY_O)
    else $error("carry out wrong");
  shift_up_a: assert property (STEP_O && $past(sh && UINST_I.shift_up)
    |-> VSB_O == $past(VSB_BELOW_I)) else $error("shift up wrong");
  shift_dn_a: assert property (STEP_O && $past(sh && !UINST_I.shift_up)
    |-> VSB_O == $past(VSB_ABOVE_I)) else $error("shift down wrong");
  vsb_hold_a: assert property (!STEP_O |-> $stable(VSB_O))
    else $error("vsb moved off step");
  cover property (STEP_O && $past(sh));
  cover property (alu && UINST_I.op2_sel == bspe_pkg::BSPE_OP2_DP1);
  cover property (STEP_O && UINST_I.cin_sel == bspe_pkg::BSPE_CIN_NBR);
  cover property (STEP_O && UINST_I.cond_en);
endmodule
bind bspe_element bspe_element_checker u_chk (
  .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .UINST_I(UINST_I), .NBR_I(NBR_I),
  .VSB_ABOVE_I(VSB_ABOVE_I), .VSB_BELOW_I(VSB_BELOW_I), .DP1_O(DP1_O),
  .CARRY_O(CARRY_O), .VSB_O(VSB_O), .STEP_O(STEP_O)
);
`default_nettype wire

/* bench/bspe_element_tb_top.sv */
// testbench: directed scenarios for the processing element
`timescale 1ns/1ps
`default_nettype none
module bspe_element_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  bspe_pkg::bspe_uinst_t ui = '0;
  logic [3:0] addr = '0;
  logic [31:0] wdat = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  // carry 0, below 0, above 1; neighbour pattern not symmetric so misindexing shows
  logic [10:0] val = 11'h14e;
  wire logic [7:0] nbr;
  wire logic abv, blw, cnb, dp1, co, vsb, stp;
  wire logic [31:0] rdat;
  wire logic [1:0] cbus;
  wire logic [1:0] cben;
  wire logic dp1e;
  logic bc = 1'b1;
  // bus 1 high and bus 0 low, so a wrong bus select shows in the edge latch
  logic [1:0] eb = 2'b10;
  int n_errors = 0;
  int samples_checked = 0;
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  bspe_element u_dut (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .UINST_I(ui), .NBR_I(nbr), .VSB_ABOVE_I(abv),
    .VSB_BELOW_I(blw), .CARRY_NBR_I(cnb), .BCAST_I(bc), .EDGE_BUS_I(eb),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdat), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(rdat), .DP1_O(dp1), .CARRY_O(co), .VSB_O(vsb), .STEP_O(stp),
    .CARRY_BUS_O(cbus), .CARRY_BUS_EN_O(cben)
  );
  // an edge element with bypass, sharing instruction and register port with u_dut
  bspe_element #(.EDGE_CARRY(1'b1), .BYPASS_EDGE(1'b1)) u_edge (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .UINST_I(ui), .NBR_I(nbr), .VSB_ABOVE_I(abv),
    .VSB_BELOW_I(blw), .CARRY_NBR_I(cnb), .BCAST_I(bc), .EDGE_BUS_I(eb),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdat), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(), .DP1_O(dp1e), .CARRY_O(), .VSB_O(), .STEP_O(),
    .CARRY_BUS_O(), .CARRY_BUS_EN_O()
  );
  bspe_nbr_model u_nbr (
    .clk_i(clk), .val_i(val), .nbr_o(nbr), .above_o(abv), .below_o(blw), .carry_o(cnb)
  );
  task automatic end_sim;
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdat;
  endtask
  task automatic wait_step;
    for (int k = 0; k < 300 && stp !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    if (stp !== 1'b1)
    begin
      n_errors++;
      end_sim;
    end
  endtask
  // a new instruction only goes in right after a step pulse, so it stands a whole step
  task automatic step(input bspe_pkg::bspe_uinst_t u);
    wait_step;
    @(posedge clk);
    ui <= u;
    #1;
    wait_step;
  endtask
  task automatic t_regs;
    logic [31:0] d;
    rd_reg(bspe_pkg::ADDR_PERIOD, d);
    chk(d, 32'(bspe_pkg::PERIOD_RST));
    @(posedge clk);
    #1;
    chk(rdat, 32'h0);
    rd_reg(bspe_pkg::ADDR_STATUS, d);
    chk(d, 32'h0);
    rd_reg(4'hc, d);
    chk(d, 32'h0);
    wr_reg(bspe_pkg::ADDR_PERIOD, 32'h0);
    rd_reg(bspe_pkg::ADDR_PERIOD, d);
    chk(d, 32'h1);
    wr_reg(bspe_pkg::ADDR_PERIOD, 32'h2);
    rd_reg(bspe_pkg::ADDR_PERIOD, d);
    chk(d, 32'h2);
  endtask
  task automatic t_alu;
    bspe_pkg::bspe_uinst_t u;
    logic [2:0] b;
    u = '0;
    u.sum_fn = 8'hff;
    u.wr_large = 1'b1;
    u.wr_small = 1'b1;
    u.large_wr = 6'h01;
    u.small_wr = 5'h01;
    step(u);
    for (int i = 0; i < 8; i++)
    begin
      b = 3'(i);
      u = '0;
      u.sum_fn = 8'hb4;
      u.carry_fn = 8'h4b;
      u.large_rd = {5'h0, b[2]};
      u.small_rd = {4'h0, b[1]};
      u.cin_sel = b[0] ? bspe_pkg::BSPE_CIN_ONE : bspe_pkg::BSPE_CIN_ZERO;
      step(u);
      chkb(dp1, u.sum_fn[b]);
      chkb(co, u.carry_fn[b]);
    end
  endtask
  task automatic t_nbr;
    bspe_pkg::bspe_uinst_t u;
    logic [31:0] d;
    for (int i = 0; i < 8; i++)
    begin
      u = '0;
      u.op2_sel = bspe_pkg::BSPE_OP2_DP1;
      u.sum_fn = 8'hcc;
      u.nbr_sel = 3'(i);
      step(u);
      chkb(dp1, val[i]);
      u.out_sel = bspe_pkg::BSPE_OUT_PASS;
      step(u);
      chkb(dp1, val[i]);
    end
    u = '0;
    u.wr_rsf = 1'b1;
    u.rsf_from_dp1 = 1'b1;
    u.nbr_sel = 3'h1;
    step(u);
    rd_reg(bspe_pkg::ADDR_STATUS, d);
    chkb(d[bspe_pkg::ST_RSF_BIT], val[1]);
    u = '0;
    u.op2_sel = bspe_pkg::BSPE_OP2_RSF;
    u.sum_fn = 8'hcc;
    step(u);
    chkb(dp1, val[1]);
  endtask
  task automatic t_shift;
    bspe_pkg::bspe_uinst_t u;
    u = '0;
    u.wr_vsb = 1'b1;
    u.sum_fn = 8'hff;
    step(u);
    chkb(vsb, 1'b1);
    u.shift_en = 1'b1;
    u.shift_up = 1'b1;
    step(u);
    chkb(vsb, val[9]);
    u.shift_up = 1'b0;
    u.sum_fn = 8'h00;
    step(u);
    chkb(vsb, val[8]);
  endtask
  task automatic t_carry;
    bspe_pkg::bspe_uinst_t u;
    logic [31:0] d;
    logic [31:0] e;
    u = '0;
    u.save_carry = 1'b1;
    u.carry_fn = 8'hff;
    u.wr_lf = 1'b1;
    u.sum_fn = 8'hff;
    step(u);
    rd_reg(bspe_pkg::ADDR_STATUS, d);
    chkb(d[bspe_pkg::ST_CSAVE_BIT], 1'b1);
    chkb(d[bspe_pkg::ST_LF_BIT], 1'b1);
    u = '0;
    u.sum_fn = 8'haa;
    u.cin_sel = bspe_pkg::BSPE_CIN_SAVE;
    step(u);
    chkb(dp1, 1'b1);
    u.cin_sel = bspe_pkg::BSPE_CIN_NBR;
    step(u);
    chkb(dp1, val[10]);
    u.cin_sel = bspe_pkg::BSPE_CIN_ONE;
    step(u);
    chkb(dp1, 1'b1);
    rd_reg(bspe_pkg::ADDR_STATUS, d);
    chkb(d[bspe_pkg::ST_LF_BIT], 1'b1);
    // back-to-back reads sample two edges apart: one commit between at period 2
    rd_reg(bspe_pkg::ADDR_STEPS, d);
    rd_reg(bspe_pkg::ADDR_STEPS, e);
    chk(e, d + 32'h1);
  endtask
  task automatic t_edge;
    bspe_pkg::bspe_uinst_t u;
    u = '0;
    u.carry_fn = 8'hff;
    u.drive_carry_bus = 1'b1;
    u.carry_bus_sel = 1'b1;
    u.ld_edge_cin = 1'b1;
    u.edge_bus_sel = 1'b1;
    step(u);
    chk(32'({cben, cbus}), 32'h0000000a);
    u = '0;
    u.sum_fn = 8'haa;
    u.cin_sel = bspe_pkg::BSPE_CIN_NBR;
    u.edge_cin_ext = 1'b1;
    step(u);
    chk(32'({cben, cbus}), 32'h00000002);
    chkb(dp1e, 1'b1);
    chkb(dp1, val[10]);
    u.edge_cin_ext = 1'b0;
    step(u);
    chkb(dp1e, 1'b0);
    u.edge_cin = 1'b1;
    step(u);
    chkb(dp1e, 1'b1);
    u.edge_cin = 1'b0;
    u.edge_cin_ext = 1'b1;
    u.ld_edge_cin = 1'b1;
    u.edge_bus_sel = 1'b0;
    step(u);
    chkb(dp1e, 1'b0);
    u = '0;
    u.out_sel = bspe_pkg::BSPE_OUT_BYPASS;
    step(u);
    chkb(dp1e, 1'b1);
    chkb(dp1, val[0]);
    @(posedge clk);
    bc <= 1'b0;
    #1;
    chkb(dp1e, 1'b0);
    chkb(stp, 1'b0);
    @(posedge clk);
    #1;
    chkb(stp, 1'b1);
  endtask
  // local flag is set by t_carry, so it serves as the status bit here
  task automatic t_cond;
    bspe_pkg::bspe_uinst_t uw;
    bspe_pkg::bspe_uinst_t ur;
    uw = '0;
    uw.wr_large = 1'b1;
    uw.large_wr = 6'h05;
    uw.sum_fn = 8'hff;
    uw.cond_en = 1'b1;
    ur = '0;
    ur.large_rd = 6'h05;
    ur.sum_fn = 8'hf0;
    step(uw);
    step(ur);
    chkb(dp1, 1'b0);
    uw.cond_val = 1'b1;
    step(uw);
    step(ur);
    chkb(dp1, 1'b1);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_alu;
    t_nbr;
    t_shift;
    t_carry;
    t_edge;
    t_cond;
    end_sim;
  end
endmodule
`default_nettype wire
